// ### logic/dpcds_pkg.sv
package dpcds_pkg;

    // parameter addresses
    localparam logic [15:0] ADDR_COMMAND    = 16'h0002;
    localparam logic [15:0] ADDR_STARTUP    = 16'h0003;
    localparam logic [15:0] ADDR_USER_SRC   = 16'h0004;
    localparam logic [15:0] ADDR_LEGACY_EXIT = 16'h0908;

    // reset values
    localparam logic [15:0] RST_COMMAND = 16'h0000;
    localparam logic [15:0] RST_STARTUP = 16'h0000;
    localparam logic [15:0] RST_USER    = 16'h0003;

    // command codes
    localparam logic [15:0] CMD_NONE     = 16'h0000;
    localparam logic [15:0] CMD_LOCK     = 16'h0001;
    localparam logic [15:0] CMD_LEG_1    = 16'h0002;
    localparam logic [15:0] CMD_ENERGY   = 16'h0005;
    localparam logic [15:0] CMD_PLC      = 16'h0006;
    localparam logic [15:0] CMD_NOP7     = 16'h0007;
    localparam logic [15:0] CMD_RUN_DIS  = 16'h0008;
    localparam logic [15:0] CMD_DEF50    = 16'h0009;
    localparam logic [15:0] CMD_DEF60    = 16'h000A;
    localparam logic [15:0] CMD_DEF50_KU = 16'h000B;
    localparam logic [15:0] CMD_DEF60_KU = 16'h000C;
    localparam logic [15:0] CMD_LEG_2    = 16'h0014;
    localparam logic [15:0] LEG_EXIT_VAL = 16'h0014;

    // startup pages
    localparam logic [15:0] PAGE_MAX = 16'h0003;

    // user display codes
    localparam logic [6:0] UD_CURRENT  = 7'h00;
    localparam logic [6:0] UD_FREQ     = 7'h02;
    localparam logic [6:0] UD_DCBUS    = 7'h03;
    localparam logic [6:0] UD_DI_LOG   = 7'h10;
    localparam logic [6:0] UD_DO_LOG   = 7'h11;
    localparam logic [6:0] UD_DI_PIN   = 7'h13;
    localparam logic [6:0] UD_DO_PIN   = 7'h14;
    localparam logic [6:0] UD_OVERLOAD = 7'h19;
    localparam logic [6:0] UD_CTRLMODE = 7'h23;
    localparam logic [6:0] UD_STATUS   = 7'h26;
    localparam logic [6:0] UD_ERROR    = 7'h3F;
    localparam logic [6:0] UD_WARN     = 7'h40;
    // listed codes as a bit map, bit n set when code n is legal
    localparam logic [65:0] UD_LEGAL_MAP = 66'h3_C409_DFD8_DE5F_5DFF;

    // status word bit positions
    localparam int ST_FWD   = 0;
    localparam int ST_REV   = 1;
    localparam int ST_READY = 2;
    localparam int ST_ERR   = 3;
    localparam int ST_RUN   = 4;
    localparam int ST_WARN  = 5;

    typedef enum logic [1:0] {
        DPCDS_FULL   = 2'b00,
        DPCDS_ARMED  = 2'b01,
        DPCDS_LEGACY = 2'b11
    } dpcds_mode_t;

    typedef struct packed {
        logic [15:0] current;
        logic [15:0] freq;
        logic [15:0] dcbus;
        logic [15:0] overload;
        logic [15:0] err_code;
        logic [15:0] warn_code;
        logic [15:0] other;
        logic [6:0]  di_logic;
        logic [2:0]  do_logic;
        logic        torque_mode;
        logic        fwd;
        logic        rev;
        logic        ready;
        logic        running;
    } dpcds_mon_t;

    typedef struct packed {
        logic        def_50hz;
        logic        def_60hz;
        logic        keep_user;
        logic        plc_erase;
    } dpcds_pend_t;

endpackage

// ### logic/dpcds_top.sv
// Function
// - command 1 locks all parameters except command and password ones until 0; the command parameter then takes only 0 or 1.
// - command 5 clears energy display and counter, allowed while running.
// - command 6 erases the internal logic-controller program.
// - command 8 disables the keypad run key.
// - commands 9 and 10 restore 50Hz or 60Hz defaults.
// - commands 11 and 12 restore defaults but keep user parameters.
// - restore commands refused while a password is set.
// - commands 6, 9, 10, 11, 12 take effect only after reboot.
// - writing 2 then 20 enters legacy mode and restores defaults.
// - in legacy mode, 20 to exit parameter returns full set, defaults.
// - startup page chosen by startup select: setpoint, freq, user, current.
// - user display select routes chosen monitored quantity to user page.
// - codes 16,17 logical I/O states; 19,20 raw pin states.
// - code 35 shows control mode, 0 speed, 1 torque.
// - code 63 shows error code, 64 shows warning code.
// - code 25 shows overload accumulation percentage.
// - code 38 shows status word of six drive flags.
module dpcds_top (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_b_i,
    // parameter access port
    input  wire logic               par_wr_i,
    input  wire logic               par_rd_i,
    input  wire logic [15:0]        par_addr_i,
    input  wire logic [15:0]        par_wdata_i,
    output logic                    par_ack_o,
    output logic                    par_err_o,
    output logic [15:0]             par_rdata_o,
    // drive state
    input  wire logic               password_set_i,
    input  wire dpcds_pkg::dpcds_mon_t mon_i,
    input  wire logic [6:0]         di_pin_i,
    input  wire logic [2:0]         do_pin_i,
    // effects
    output logic                    params_locked_o,
    output logic                    energy_clear_o,
    output logic                    run_key_disable_o,
    output dpcds_pkg::dpcds_pend_t  reboot_pend_o,
    output logic                    legacy_mode_o,
    output logic                    restore_now_o,
    // display
    output logic [1:0]              startup_page_o,
    output logic [6:0]              user_source_o,
    output logic [15:0]             user_value_o
);

    // codes past the map are refused before it is indexed
    function automatic logic ud_legal(input logic [15:0] code);
        ud_legal = (code < 16'd66) && dpcds_pkg::UD_LEGAL_MAP[code[6:0]];
    endfunction

    // the four restore codes share password and reboot handling
    function automatic logic is_restore(input logic [15:0] code);
        is_restore = (code == dpcds_pkg::CMD_DEF50)
                   || (code == dpcds_pkg::CMD_DEF60)
                   || (code == dpcds_pkg::CMD_DEF50_KU)
                   || (code == dpcds_pkg::CMD_DEF60_KU);
    endfunction

    logic [15:0]            cmd_reg;
    logic [15:0]            cmd_next;
    logic [1:0]             startup_reg;
    logic [6:0]             user_reg;
    dpcds_pkg::dpcds_mode_t mode_reg;
    dpcds_pkg::dpcds_mode_t mode_next;
    dpcds_pkg::dpcds_pend_t pend_reg;
    dpcds_pkg::dpcds_pend_t pend_next;
    logic                   run_dis_reg;
    logic                   energy_reg;
    logic                   restore_reg;
    logic                   ack_reg;
    logic                   err_reg;
    logic [15:0]            rdata_reg;
    logic [15:0]            uval_reg;
    logic                   lock_reg;
    logic                   legacy_reg;
    wire  [9:0]             pin_raw;
    wire  [9:0]             pin_sync;
    wire  [6:0]             di_sync;
    wire  [2:0]             do_sync;

    // address decode
    wire hit_cmd  = par_addr_i == dpcds_pkg::ADDR_COMMAND;
    wire hit_st   = par_addr_i == dpcds_pkg::ADDR_STARTUP;
    wire hit_usr  = par_addr_i == dpcds_pkg::ADDR_USER_SRC;
    wire hit_exit = par_addr_i == dpcds_pkg::ADDR_LEGACY_EXIT;
    wire locked   = cmd_reg == dpcds_pkg::CMD_LOCK;
    wire wr_cmd   = par_wr_i && hit_cmd;
    wire wr_st    = par_wr_i && hit_st;
    wire wr_usr   = par_wr_i && hit_usr;
    wire wr_exit  = par_wr_i && hit_exit;
    wire [15:0] wd = par_wdata_i;

    // command legality
    wire cmd_listed = (wd == dpcds_pkg::CMD_NONE)
                   || (wd == dpcds_pkg::CMD_LOCK)
                   || (wd == dpcds_pkg::CMD_LEG_1)
                   || (wd == dpcds_pkg::CMD_ENERGY)
                   || (wd == dpcds_pkg::CMD_PLC)
                   || (wd == dpcds_pkg::CMD_NOP7)
                   || (wd == dpcds_pkg::CMD_RUN_DIS)
                   || is_restore(wd)
                   || (wd == dpcds_pkg::CMD_LEG_2);
    // step two only counts straight after step one
    wire leg2_ok    = (wd != dpcds_pkg::CMD_LEG_2)
                   || (mode_reg == dpcds_pkg::DPCDS_ARMED);
    wire pw_block   = password_set_i
                   && (is_restore(wd) || (wd == dpcds_pkg::CMD_LEG_2));
    // while locked only a return to 0 or a relock is taken
    wire lock_ok    = !locked || (wd == dpcds_pkg::CMD_NONE)
                   || (wd == dpcds_pkg::CMD_LOCK);
    wire cmd_take   = wr_cmd && cmd_listed && leg2_ok && !pw_block
                   && lock_ok;
    wire st_take    = wr_st && !locked && (wd <= dpcds_pkg::PAGE_MAX);
    wire usr_take   = wr_usr && !locked && ud_legal(wd);
    wire exit_take  = wr_exit && !locked
                   && (mode_reg == dpcds_pkg::DPCDS_LEGACY)
                   && (wd == dpcds_pkg::LEG_EXIT_VAL);
    wire wr_ok      = cmd_take || st_take || usr_take || exit_take;
    wire unmapped   = !(hit_cmd || hit_st || hit_usr || hit_exit);
    wire access     = par_wr_i || par_rd_i;
    // a refused write answers with err and stores nothing
    wire wr_refused = par_wr_i && !wr_ok;
    wire err_next   = access && (unmapped || wr_refused);
    // a write wins over a read in the same cycle
    wire rd_only    = par_rd_i && !par_wr_i;

    // command effects fire only on the accepting write
    wire ev_energy  = cmd_take && (wd == dpcds_pkg::CMD_ENERGY);
    wire ev_plc     = cmd_take && (wd == dpcds_pkg::CMD_PLC);
    wire ev_rundis  = cmd_take && (wd == dpcds_pkg::CMD_RUN_DIS);
    wire ev_leg1    = cmd_take && (wd == dpcds_pkg::CMD_LEG_1);
    wire ev_leg2    = cmd_take && (wd == dpcds_pkg::CMD_LEG_2);

    always_comb begin
        // the stored code only changes on an accepted write
        cmd_next = cmd_reg;
        if (cmd_take) begin
            cmd_next = wd;
        end
    end

    always_comb begin
        pend_next = pend_reg;
        if (ev_plc) begin
            pend_next.plc_erase = 1'b1;
        end
        if (cmd_take && is_restore(wd)) begin
            // last restore request before reboot wins
            pend_next.def_50hz  = (wd == dpcds_pkg::CMD_DEF50)
                               || (wd == dpcds_pkg::CMD_DEF50_KU);
            pend_next.def_60hz  = (wd == dpcds_pkg::CMD_DEF60)
                               || (wd == dpcds_pkg::CMD_DEF60_KU);
            pend_next.keep_user = (wd == dpcds_pkg::CMD_DEF50_KU)
                               || (wd == dpcds_pkg::CMD_DEF60_KU);
        end
    end

    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            dpcds_pkg::DPCDS_FULL: begin
                if (ev_leg1) begin
                    mode_next = dpcds_pkg::DPCDS_ARMED;
                end
            end
            // no timeout: only the next accepted command disarms
            dpcds_pkg::DPCDS_ARMED: begin
                if (ev_leg2) begin
                    mode_next = dpcds_pkg::DPCDS_LEGACY;
                end else if (cmd_take) begin
                    mode_next = dpcds_pkg::DPCDS_FULL;
                end
            end
            dpcds_pkg::DPCDS_LEGACY: begin
                if (exit_take) begin
                    mode_next = dpcds_pkg::DPCDS_FULL;
                end
            end
            default: mode_next = dpcds_pkg::DPCDS_FULL;
        endcase
    end

    // user display source mux
    logic [15:0] uval_next;
    logic [15:0] status_word;
    // error and warning bits follow nonzero codes, nothing is latched
    always_comb begin
        status_word = 16'h0000;
        status_word[dpcds_pkg::ST_FWD]   = mon_i.fwd;
        status_word[dpcds_pkg::ST_REV]   = mon_i.rev;
        status_word[dpcds_pkg::ST_READY] = mon_i.ready;
        status_word[dpcds_pkg::ST_ERR]   = mon_i.err_code != 16'h0000;
        status_word[dpcds_pkg::ST_RUN]   = mon_i.running;
        status_word[dpcds_pkg::ST_WARN]  = mon_i.warn_code != 16'h0000;
    end

    always_comb begin
        unique case (user_reg)
            dpcds_pkg::UD_CURRENT:  uval_next = mon_i.current;
            dpcds_pkg::UD_FREQ:     uval_next = mon_i.freq;
            dpcds_pkg::UD_DCBUS:    uval_next = mon_i.dcbus;
            dpcds_pkg::UD_DI_LOG:   uval_next = {9'h000, mon_i.di_logic};
            dpcds_pkg::UD_DO_LOG:   uval_next = {13'h0000, mon_i.do_logic};
            dpcds_pkg::UD_DI_PIN:   uval_next = {9'h000, di_sync};
            dpcds_pkg::UD_DO_PIN:   uval_next = {13'h0000, do_sync};
            dpcds_pkg::UD_OVERLOAD: uval_next = mon_i.overload;
            dpcds_pkg::UD_CTRLMODE: uval_next = {15'h0000, mon_i.torque_mode};
            dpcds_pkg::UD_STATUS:   uval_next = status_word;
            dpcds_pkg::UD_ERROR:    uval_next = mon_i.err_code;
            dpcds_pkg::UD_WARN:     uval_next = mon_i.warn_code;
            // remaining listed sources live outside, keyed by user_source_o
            default:                uval_next = mon_i.other;
        endcase
    end

    // read data
    // the exit parameter acts on write only and reads as zero
    logic [15:0] rd_next;
    always_comb begin
        rd_next = 16'h0000;
        if (hit_cmd) begin
            rd_next = cmd_reg;
        end else if (hit_st) begin
            rd_next = {14'h0000, startup_reg};
        end else if (hit_usr) begin
            rd_next = {9'h000, user_reg};
        end
    end

    // pin states cross in through two flops, one pair per pin
    // a pin change near the edge may show a cycle late, and pins changing together may land in different cycles
    assign pin_raw = {do_pin_i, di_pin_i};
    assign di_sync = pin_sync[6:0];
    assign do_sync = pin_sync[9:7];

    generate
        for (genvar gi = 0; gi < 10; gi++) begin : g_sync
            logic meta_reg;
            logic sync_reg;

            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end else begin
                    meta_reg <= pin_raw[gi];
                    sync_reg <= meta_reg;
                end
            end
            // only the second flop is read past this point
            assign pin_sync[gi] = sync_reg;
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_reg     <= dpcds_pkg::RST_COMMAND;
            startup_reg <= dpcds_pkg::RST_STARTUP[1:0];
            user_reg    <= dpcds_pkg::RST_USER[6:0];
            mode_reg    <= dpcds_pkg::DPCDS_FULL;
        end else begin
            cmd_reg  <= cmd_next;
            mode_reg <= mode_next;
            if (st_take) begin
                startup_reg <= wd[1:0];
            end
            if (usr_take) begin
                user_reg <= wd[6:0];
            end
        end
    end

    // pending restore requests clear only at reboot
    // nothing re-enables the run key short of a reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_reg    <= '0;
            run_dis_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            if (ev_rundis) begin
                run_dis_reg <= 1'b1;
            end
        end
    end

    // effect pulses last one cycle; receivers must take them then
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            energy_reg  <= 1'b0;
            restore_reg <= 1'b0;
        end else begin
            energy_reg  <= ev_energy;
            restore_reg <= ev_leg2 || exit_take;
        end
    end

    // level outputs leave from flops, not from compare logic
    wire lock_next   = cmd_next == dpcds_pkg::CMD_LOCK;
    wire legacy_next = mode_next == dpcds_pkg::DPCDS_LEGACY;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            uval_reg   <= 16'h0000;
            lock_reg   <= 1'b0;
            legacy_reg <= 1'b0;
        end else begin
            uval_reg   <= uval_next;
            lock_reg   <= lock_next;
            legacy_reg <= legacy_next;
        end
    end

    // every access is answered on the next edge, no wait states
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            ack_reg   <= access;
            err_reg   <= err_next;
            rdata_reg <= rd_only ? rd_next : 16'h0000;
        end
    end

    assign par_ack_o         = ack_reg;
    assign par_err_o         = err_reg;
    assign par_rdata_o       = rdata_reg;
    assign params_locked_o   = lock_reg;
    assign energy_clear_o    = energy_reg;
    assign run_key_disable_o = run_dis_reg;
    assign reboot_pend_o     = pend_reg;
    assign legacy_mode_o     = legacy_reg;
    assign restore_now_o     = restore_reg;
    assign startup_page_o    = startup_reg;
    assign user_source_o     = user_reg;
    assign user_value_o      = uval_reg;

endmodule

// ### bench/dpcds_assertions.sv
module dpcds_assertions (
    // clock and reset
    input wire logic                   clk_i,
    input wire logic                   rst_b_i,
    // parameter access port
    input wire logic                   par_wr_i,
    input wire logic                   par_rd_i,
    input wire logic [15:0]            par_addr_i,
    input wire logic [15:0]            par_wdata_i,
    input wire logic                   par_ack_o,
    input wire logic                   par_err_o,
    input wire logic [15:0]            par_rdata_o,
    // drive state
    input wire logic                   password_set_i,
    input wire dpcds_pkg::dpcds_mon_t  mon_i,
    input wire logic [6:0]             di_pin_i,
    input wire logic [2:0]             do_pin_i,
    // effects and display
    input wire logic                   params_locked_o,
    input wire logic                   energy_clear_o,
    input wire logic                   run_key_disable_o,
    input wire dpcds_pkg::dpcds_pend_t reboot_pend_o,
    input wire logic                   legacy_mode_o,
    input wire logic                   restore_now_o,
    input wire logic [1:0]             startup_page_o,
    input wire logic [6:0]             user_source_o,
    input wire logic [15:0]            user_value_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_restore_req;
        par_wr_i && par_addr_i == 16'h0002 && password_set_i
            && par_wdata_i inside {[16'h0009:16'h000C]};
    endsequence
    sequence s_err_sel;
        user_source_o == 7'h3F ##1 user_source_o == 7'h3F;
    endsequence

    property p_lock;
        params_locked_o && par_wr_i && par_addr_i == 16'h0003
            |=> par_ack_o && par_err_o;
    endproperty
    a_lock: assert property (p_lock) else $error("locked write taken");
    property p_energy;
        energy_clear_o |-> par_ack_o && !par_err_o
            && $past(par_addr_i) == 16'h0002 && $past(par_wdata_i) == 16'h0005;
    endproperty
    a_energy: assert property (p_energy) else $error("stray clear");
    property p_once;
        energy_clear_o && !par_wr_i |=> !energy_clear_o;
    endproperty
    a_once: assert property (p_once) else $error("clear repeated");
    property p_runkey;
        run_key_disable_o |=> run_key_disable_o;
    endproperty
    a_runkey: assert property (p_runkey) else $error("run key freed");
    property p_pass;
        s_restore_req |=> par_err_o && $stable(reboot_pend_o);
    endproperty
    a_pass: assert property (p_pass) else $error("restore not refused");
    property p_restore;
        restore_now_o |-> par_ack_o && !par_err_o
            && $past(par_wdata_i) == 16'h0014;
    endproperty
    a_restore: assert property (p_restore) else $error("bad restore");
    property p_reject;
        par_ack_o && par_err_o |-> $stable(startup_page_o)
            && $stable(user_source_o);
    endproperty
    a_reject: assert property (p_reject) else $error("refused but stored");
    property p_err_page;
        s_err_sel |-> user_value_o == $past(mon_i.err_code);
    endproperty
    a_err_page: assert property (p_err_page) else $error("bad error page");
endmodule

bind dpcds_top dpcds_assertions dpcds_assertions_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .par_wr_i(par_wr_i),
    .par_rd_i(par_rd_i), .par_addr_i(par_addr_i),
    .par_wdata_i(par_wdata_i), .par_ack_o(par_ack_o),
    .par_err_o(par_err_o), .par_rdata_o(par_rdata_o),
    .password_set_i(password_set_i), .mon_i(mon_i), .di_pin_i(di_pin_i),
    .do_pin_i(do_pin_i), .params_locked_o(params_locked_o),
    .energy_clear_o(energy_clear_o), .run_key_disable_o(run_key_disable_o),
    .reboot_pend_o(reboot_pend_o), .legacy_mode_o(legacy_mode_o),
    .restore_now_o(restore_now_o), .startup_page_o(startup_page_o),
    .user_source_o(user_source_o), .user_value_o(user_value_o)
);

// ### bench/dpcds_top_test.sv
module dpcds_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk_i, rst_b_i, par_wr_i, par_rd_i;
    logic                   par_ack_o, par_err_o, password_set_i;
    logic                   params_locked_o, energy_clear_o, restore_now_o;
    logic                   run_key_disable_o, legacy_mode_o;
    logic [15:0]            par_addr_i, par_wdata_i, par_rdata_o;
    logic [15:0]            user_value_o;
    logic [6:0]             di_pin_i, user_source_o;
    logic [2:0]             do_pin_i;
    logic [1:0]             startup_page_o;
    dpcds_pkg::dpcds_mon_t  mon_i;
    dpcds_pkg::dpcds_pend_t reboot_pend_o;
    int                     err_count, compares;

    dpcds_top dpcds_top_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .par_wr_i(par_wr_i),
        .par_rd_i(par_rd_i), .par_addr_i(par_addr_i),
        .par_wdata_i(par_wdata_i), .par_ack_o(par_ack_o),
        .par_err_o(par_err_o), .par_rdata_o(par_rdata_o),
        .password_set_i(password_set_i), .mon_i(mon_i),
        .di_pin_i(di_pin_i), .do_pin_i(do_pin_i),
        .params_locked_o(params_locked_o), .energy_clear_o(energy_clear_o),
        .run_key_disable_o(run_key_disable_o),
        .reboot_pend_o(reboot_pend_o), .legacy_mode_o(legacy_mode_o),
        .restore_now_o(restore_now_o), .startup_page_o(startup_page_o),
        .user_source_o(user_source_o), .user_value_o(user_value_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one access, request held for exactly the taking edge
    task automatic access(input logic wr, input logic [15:0] addr,
                          input logic [15:0] data, input logic e_err,
                          input logic [15:0] e_rd);
        int n;
        @(posedge clk_i);
        #1;
        par_wr_i = wr;
        par_rd_i = ~wr;
        par_addr_i = addr;
        par_wdata_i = data;
        @(posedge clk_i);
        #1;
        par_wr_i = 1'b0;
        par_rd_i = 1'b0;
        n = 0;
        while (par_ack_o !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n == 4) begin
            err_count++;
            print_verdict();
        end else begin
            check({15'h0, par_err_o}, {15'h0, e_err});
            check(par_rdata_o, e_rd);
        end
    endtask

    task automatic t_reset();
        check({14'h0, startup_page_o}, 16'h0000);
        check({9'h0, user_source_o}, 16'h0003);
        access(1'b0, 16'h0002, 16'h0000, 1'b0, 16'h0000);
        access(1'b0, 16'h0004, 16'h0000, 1'b0, 16'h0003);
        access(1'b0, 16'h0005, 16'h0000, 1'b1, 16'h0000);
    endtask

    task automatic t_energy();
        access(1'b1, 16'h0002, 16'h0005, 1'b0, 16'h0000);
        check({15'h0, energy_clear_o}, 16'h0001);
        @(posedge clk_i);
        #1;
        check({15'h0, energy_clear_o}, 16'h0000);
        access(1'b0, 16'h0002, 16'h0000, 1'b0, 16'h0005);
    endtask

    task automatic t_runkey();
        access(1'b1, 16'h0002, 16'h0008, 1'b0, 16'h0000);
        access(1'b1, 16'h0002, 16'h0000, 1'b0, 16'h0000);
        check({15'h0, run_key_disable_o}, 16'h0001);
    endtask

    task automatic t_lock();
        access(1'b1, 16'h0002, 16'h0001, 1'b0, 16'h0000);
        check({15'h0, params_locked_o}, 16'h0001);
        access(1'b1, 16'h0003, 16'h0001, 1'b1, 16'h0000);
        access(1'b1, 16'h0004, 16'h0000, 1'b1, 16'h0000);
        access(1'b1, 16'h0002, 16'h0005, 1'b1, 16'h0000);
        check({15'h0, energy_clear_o}, 16'h0000);
        access(1'b1, 16'h0002, 16'h0000, 1'b0, 16'h0000);
        check({15'h0, params_locked_o}, 16'h0000);
    endtask

    task automatic t_restore();
        logic [3:0] pexp [4];
        pexp = '{4'h9, 4'h5, 4'hB, 4'h7};
        password_set_i = 1'b1;
        for (int c = 9; c <= 12; c++)
            access(1'b1, 16'h0002, 16'(c), 1'b1, 16'h0000);
        check({12'h0, reboot_pend_o}, 16'h0000);
        password_set_i = 1'b0;
        access(1'b1, 16'h0002, 16'h0006, 1'b0, 16'h0000);
        check({12'h0, reboot_pend_o}, 16'h0001);
        for (int c = 9; c <= 12; c++) begin
            access(1'b1, 16'h0002, 16'(c), 1'b0, 16'h0000);
            check({12'h0, reboot_pend_o}, {12'h0, pexp[c-9]});
        end
    endtask

    task automatic t_invalid();
        access(1'b1, 16'h0002, 16'h0003, 1'b1, 16'h0000);
        access(1'b1, 16'h0003, 16'h0004, 1'b1, 16'h0000);
        access(1'b1, 16'h0004, 16'h0009, 1'b1, 16'h0000);
        access(1'b1, 16'h0004, 16'h000F, 1'b1, 16'h0000);
        access(1'b1, 16'h0004, 16'h0042, 1'b1, 16'h0000);
        access(1'b0, 16'h0004, 16'h0000, 1'b0, 16'h0003);
    endtask

    task automatic t_display();
        logic [15:0] code [13];
        logic [15:0] want [13];
        code = '{16'h00, 16'h02, 16'h03, 16'h10, 16'h11, 16'h13, 16'h14,
                 16'h19, 16'h23, 16'h26, 16'h3F, 16'h40, 16'h01};
        want = '{16'h1111, 16'h2222, 16'h3333, 16'h0021, 16'h0001,
                 16'h005A, 16'h0006, 16'h2710, 16'h0001, 16'h003D,
                 16'h0041, 16'h0052, 16'h7777};
        for (int p = 0; p < 4; p++) begin
            access(1'b1, 16'h0003, 16'(p), 1'b0, 16'h0000);
            check({14'h0, startup_page_o}, 16'(p));
        end
        for (int i = 0; i < 13; i++) begin
            access(1'b1, 16'h0004, code[i], 1'b0, 16'h0000);
            @(posedge clk_i);
            #1;
            check(user_value_o, want[i]);
        end
    endtask

    task automatic t_legacy();
        access(1'b1, 16'h0908, 16'h0014, 1'b1, 16'h0000);
        access(1'b1, 16'h0002, 16'h0014, 1'b1, 16'h0000);
        access(1'b1, 16'h0002, 16'h0002, 1'b0, 16'h0000);
        password_set_i = 1'b1;
        access(1'b1, 16'h0002, 16'h0014, 1'b1, 16'h0000);
        password_set_i = 1'b0;
        access(1'b1, 16'h0002, 16'h0014, 1'b0, 16'h0000);
        check({14'h0, restore_now_o, legacy_mode_o}, 16'h0003);
        access(1'b1, 16'h0908, 16'h0014, 1'b0, 16'h0000);
        check({14'h0, restore_now_o, legacy_mode_o}, 16'h0002);
    endtask

    initial begin
        err_count = 0;
        compares = 0;
        rst_b_i = 1'b0;
        par_wr_i = 1'b0;
        par_rd_i = 1'b0;
        par_addr_i = 16'h0000;
        par_wdata_i = 16'h0000;
        password_set_i = 1'b0;
        di_pin_i = 7'h5A;
        do_pin_i = 3'h6;
        mon_i = '{16'h1111, 16'h2222, 16'h3333, 16'h2710, 16'h0041,
                  16'h0052, 16'h7777, 7'h21, 3'h1, 1'b1, 1'b1, 1'b0,
                  1'b1, 1'b1};
        repeat (2) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        t_reset();
        t_energy();
        t_runkey();
        t_lock();
        t_restore();
        t_invalid();
        t_display();
        t_legacy();
        print_verdict();
    end
endmodule
